// *** rtl/dbg_cmd_pkg.sv ***
// constants and types shared by both ends of the debug command link
package dbg_cmd_pkg;

   // ==========================================
   // command opcodes
   localparam logic [7:0] OP_REG_RD = 8'h09;
   localparam logic [7:0] OP_PM_WR = 8'h0a;
   localparam logic [7:0] OP_PM_RD = 8'h0b;
   localparam logic [7:0] OP_DM_WR = 8'h0c;
   localparam logic [7:0] BLOCKED_BYTE = 8'hff;

   // ==========================================
   // transfer sizes, 17 bits so that the zero encodings fit
   localparam logic [16:0] REG_MAX = 17'h00100;
   localparam logic [16:0] MEM_MAX = 17'h10000;
   localparam logic [16:0] CNT_ONE = 17'h00001;

   // ==========================================
   // bit timing on the pin, in clock cycles
   localparam int BIT_CYCLES = 16;
   localparam logic [3:0] BIT_LAST = 4'(BIT_CYCLES - 1);
   localparam logic [3:0] HALF_LAST = 4'(BIT_CYCLES / 2 - 1);
   localparam logic [3:0] RX_STOP_BIT = 4'h9;
   localparam logic [3:0] TX_LAST_BIT = 4'ha;

   // ==========================================
   // values after reset
   localparam logic [15:0] ADDR_RST = 16'h0000;
   localparam logic [16:0] CNT_RST = 17'h00000;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [2:0] IDX_RST = 3'h0;
   localparam logic [10:0] SH_RST = 11'h7ff;

   // ==========================================
   // memory spaces seen on the device's user side
   typedef enum logic [1:0] {
      SP_REG = 2'h0,
      SP_PROG = 2'h1,
      SP_DATA = 2'h2
   } space_e;

   // line engine: idle, receiving a frame, sending a frame
   typedef enum logic [2:0] {
      PH_IDLE = 3'b001,
      PH_RX = 3'b010,
      PH_TX = 3'b100
   } phy_e;

   typedef enum logic [9:0] {
      D_IDLE = 10'b0000000001,
      D_AH = 10'b0000000010,
      D_AL = 10'b0000000100,
      D_SH = 10'b0000001000,
      D_SL = 10'b0000010000,
      D_WR = 10'b0000100000,
      D_FETCH = 10'b0001000000,
      D_WAIT = 10'b0010000000,
      D_LOAD = 10'b0100000000,
      D_SEND = 10'b1000000000
   } dev_state_e;

   typedef enum logic [5:0] {
      H_IDLE = 6'b000001,
      H_HDR = 6'b000010,
      H_HWAIT = 6'b000100,
      H_WDATA = 6'b001000,
      H_WWAIT = 6'b010000,
      H_READ = 6'b100000
   } host_state_e;

endpackage : dbg_cmd_pkg

// *** rtl/debug_link_if.sv ***
// the open-drain debug pin shared by device and host
`timescale 1ns/10ps
interface debug_link_if;
   logic dev_o;
   logic dev_oe_n;
   logic host_o;
   logic host_oe_n;
   logic debug_serial_pin;

   // pulled high unless an enabled end pulls it low
   assign debug_serial_pin = !((!dev_oe_n && !dev_o) || (!host_oe_n && !host_o));

   modport device (output dev_o, output dev_oe_n, input debug_serial_pin);
   modport host (output host_o, output host_oe_n, input debug_serial_pin);
endinterface : debug_link_if

// *** rtl/debug_cmd_device.sv ***
// device end: runs debug memory commands received on the pin
`timescale 1ns/10ps
module debug_cmd_device (
   input wire logic clock,
   input wire logic nrst,
   debug_link_if.device link,
   input wire logic debug_mode,
   input wire logic read_protect,
   input wire logic flash_unlocked,
   output dbg_cmd_pkg::space_e mem_space,
   output logic [15:0] mem_addr,
   output logic [7:0] mem_wdata,
   output logic mem_we,
   output logic mem_re,
   input wire logic [7:0] mem_rdata,
   output logic busy
);
   import dbg_cmd_pkg::*;

   // ==========================================
   // pin synchroniser
   logic s1_r, s2_r, s3_r, lvl_r, lvl_nxt;

   always_comb begin
      lvl_nxt = (s2_r == s3_r) ? s2_r : lvl_r;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s1_r <= 1'b1;
         s2_r <= 1'b1;
         s3_r <= 1'b1;
         lvl_r <= 1'b1;
      end else begin
         s1_r <= link.debug_serial_pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
         lvl_r <= lvl_nxt;
      end
   end

   // ==========================================
   // line engine, half duplex
   phy_e ph_r, ph_nxt;
   logic [3:0] tick_r, tick_nxt, bit_r, bit_nxt;
   logic [10:0] sh_r, sh_nxt;
   logic oen_r, oen_nxt;
   logic rx_stb, tx_done, tx_go;
   logic [7:0] tx_byte, rx_byte;

   assign rx_byte = sh_r[7:0];
   assign link.dev_o = 1'b0;
   assign link.dev_oe_n = oen_r;

   always_comb begin
      ph_nxt = ph_r;
      tick_nxt = tick_r;
      bit_nxt = bit_r;
      sh_nxt = sh_r;
      oen_nxt = oen_r;
      rx_stb = 1'b0;
      tx_done = 1'b0;
      case (ph_r)
         PH_IDLE: begin
            // one released bit leads each frame so the far end is listening
            if (tx_go) begin
               ph_nxt = PH_TX;
               sh_nxt = {1'b1, tx_byte, 1'b0, 1'b1};
               tick_nxt = BIT_LAST;
               bit_nxt = 4'h0;
               oen_nxt = 1'b1;
            end else if (!lvl_r) begin
               ph_nxt = PH_RX;
               tick_nxt = HALF_LAST;
               bit_nxt = 4'h0;
            end
         end
         PH_RX: begin
            if (tick_r != 4'h0) begin
               tick_nxt = tick_r - 4'h1;
            end else begin
               tick_nxt = BIT_LAST;
               bit_nxt = bit_r + 4'h1;
               if (bit_r == 4'h0 && lvl_r) begin
                  ph_nxt = PH_IDLE;
               end else if (bit_r == RX_STOP_BIT) begin
                  ph_nxt = PH_IDLE;
                  rx_stb = lvl_r;
               end else if (bit_r != 4'h0) begin
                  sh_nxt = {sh_r[10:8], lvl_r, sh_r[7:1]};
               end
            end
         end
         PH_TX: begin
            if (tick_r != 4'h0) begin
               tick_nxt = tick_r - 4'h1;
            end else begin
               tick_nxt = BIT_LAST;
               bit_nxt = bit_r + 4'h1;
               sh_nxt = {1'b1, sh_r[10:1]};
               if (bit_r == TX_LAST_BIT) begin
                  ph_nxt = PH_IDLE;
                  tx_done = 1'b1;
                  oen_nxt = 1'b1;
               end else begin
                  oen_nxt = sh_r[1];
               end
            end
         end
         default: begin
            ph_nxt = PH_IDLE;
            oen_nxt = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ph_r <= PH_IDLE;
         tick_r <= 4'h0;
         bit_r <= 4'h0;
         sh_r <= SH_RST;
         oen_r <= 1'b1;
      end else begin
         ph_r <= ph_nxt;
         tick_r <= tick_nxt;
         bit_r <= bit_nxt;
         sh_r <= sh_nxt;
         oen_r <= oen_nxt;
      end
   end

   // ==========================================
   // command sequencer
   dev_state_e st_r, st_nxt;
   logic [7:0] op_r, op_nxt, wd_r, wd_nxt;
   logic [15:0] addr_r, addr_nxt;
   logic [16:0] cnt_r, cnt_nxt;
   space_e sp_r, sp_nxt;
   logic we_r, we_nxt, re_r, re_nxt, step_r, step_nxt;
   logic open_ok, wr_ok, is_wr;

   assign open_ok = debug_mode && !read_protect;
   assign is_wr = (op_r == OP_PM_WR) || (op_r == OP_DM_WR);
   // flash also needs its controller unlocked
   assign wr_ok = open_ok && (op_r == OP_DM_WR || flash_unlocked);
   assign tx_go = (st_r == D_LOAD);
   // blocked reads still strobe memory; only the reply is masked
   assign tx_byte = open_ok ? mem_rdata : BLOCKED_BYTE;

   assign mem_space = sp_r;
   assign mem_addr = addr_r;
   assign mem_wdata = wd_r;
   assign mem_we = we_r;
   assign mem_re = re_r;
   assign busy = (st_r != D_IDLE);

   always_comb begin
      st_nxt = st_r;
      op_nxt = op_r;
      wd_nxt = wd_r;
      addr_nxt = addr_r;
      cnt_nxt = cnt_r;
      sp_nxt = sp_r;
      we_nxt = 1'b0;
      re_nxt = 1'b0;
      step_nxt = 1'b0;
      if (step_r) begin
         addr_nxt = addr_r + 16'h0001;
      end
      case (st_r)
         D_IDLE: begin
            if (rx_stb) begin
               op_nxt = rx_byte;
               sp_nxt = (rx_byte == OP_REG_RD) ? SP_REG :
                        (rx_byte == OP_DM_WR) ? SP_DATA : SP_PROG;
               // unknown opcodes are dropped and the next byte is a new command
               if (rx_byte == OP_REG_RD || rx_byte == OP_PM_WR ||
                   rx_byte == OP_PM_RD || rx_byte == OP_DM_WR) begin
                  st_nxt = D_AH;
               end
            end
         end
         D_AH: begin
            if (rx_stb) begin
               // register space is 12 bits wide
               addr_nxt[15:8] = (op_r == OP_REG_RD) ? {4'h0, rx_byte[3:0]} : rx_byte;
               st_nxt = D_AL;
            end
         end
         D_AL: begin
            if (rx_stb) begin
               addr_nxt[7:0] = rx_byte;
               st_nxt = (op_r == OP_REG_RD) ? D_SL : D_SH;
            end
         end
         D_SH: begin
            if (rx_stb) begin
               cnt_nxt = {1'b0, rx_byte, 8'h00};
               st_nxt = D_SL;
            end
         end
         D_SL: begin
            if (rx_stb) begin
               if (op_r == OP_REG_RD) begin
                  cnt_nxt = (rx_byte == 8'h00) ? REG_MAX : {9'h000, rx_byte};
               end else if (cnt_r[15:8] == 8'h00 && rx_byte == 8'h00) begin
                  cnt_nxt = MEM_MAX;
               end else begin
                  cnt_nxt = {1'b0, cnt_r[15:8], rx_byte};
               end
               st_nxt = is_wr ? D_WR : D_FETCH;
            end
         end
         D_WR: begin
            if (rx_stb) begin
               we_nxt = wr_ok;
               wd_nxt = rx_byte;
               step_nxt = 1'b1;
               cnt_nxt = cnt_r - CNT_ONE;
               if (cnt_r == CNT_ONE) begin
                  st_nxt = D_IDLE;
               end
            end
         end
         D_FETCH: begin
            re_nxt = 1'b1;
            st_nxt = D_WAIT;
         end
         D_WAIT: begin
            st_nxt = D_LOAD;
         end
         D_LOAD: begin
            st_nxt = D_SEND;
         end
         D_SEND: begin
            if (tx_done) begin
               step_nxt = 1'b1;
               cnt_nxt = cnt_r - CNT_ONE;
               st_nxt = (cnt_r == CNT_ONE) ? D_IDLE : D_FETCH;
            end
         end
         default: begin
            st_nxt = D_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         st_r <= D_IDLE;
         op_r <= BYTE_RST;
         wd_r <= BYTE_RST;
         addr_r <= ADDR_RST;
         cnt_r <= CNT_RST;
         sp_r <= SP_REG;
         we_r <= 1'b0;
         re_r <= 1'b0;
         step_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         op_r <= op_nxt;
         wd_r <= wd_nxt;
         addr_r <= addr_nxt;
         cnt_r <= cnt_nxt;
         sp_r <= sp_nxt;
         we_r <= we_nxt;
         re_r <= re_nxt;
         step_r <= step_nxt;
      end
   end

endmodule : debug_cmd_device

// *** rtl/debug_cmd_host.sv ***
// host end: sends one debug memory command and moves its data
`timescale 1ns/10ps
module debug_cmd_host (
   input wire logic clock,
   input wire logic nrst,
   debug_link_if.host link,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [7:0] cmd_op,
   input wire logic [15:0] cmd_addr,
   input wire logic [15:0] cmd_size,
   input wire logic wr_valid,
   input wire logic [7:0] wr_data,
   output logic wr_ready,
   output logic rd_valid,
   output logic [7:0] rd_data,
   output logic busy
);
   import dbg_cmd_pkg::*;

   // ==========================================
   // pin synchroniser
   logic s1_r, s2_r, s3_r, lvl_r, lvl_nxt;

   always_comb begin
      lvl_nxt = (s2_r == s3_r) ? s2_r : lvl_r;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s1_r <= 1'b1;
         s2_r <= 1'b1;
         s3_r <= 1'b1;
         lvl_r <= 1'b1;
      end else begin
         s1_r <= link.debug_serial_pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
         lvl_r <= lvl_nxt;
      end
   end

   // ==========================================
   // line engine, same framing as the device
   phy_e ph_r, ph_nxt;
   logic [3:0] tick_r, tick_nxt, bit_r, bit_nxt;
   logic [10:0] sh_r, sh_nxt;
   logic oen_r, oen_nxt;
   logic rx_stb, tx_done, tx_go;
   logic [7:0] tx_byte;

   assign link.host_o = 1'b0;
   assign link.host_oe_n = oen_r;

   always_comb begin
      ph_nxt = ph_r;
      tick_nxt = tick_r;
      bit_nxt = bit_r;
      sh_nxt = sh_r;
      oen_nxt = oen_r;
      rx_stb = 1'b0;
      tx_done = 1'b0;
      case (ph_r)
         PH_IDLE: begin
            if (tx_go) begin
               ph_nxt = PH_TX;
               sh_nxt = {1'b1, tx_byte, 1'b0, 1'b1};
               tick_nxt = BIT_LAST;
               bit_nxt = 4'h0;
               oen_nxt = 1'b1;
            end else if (!lvl_r) begin
               ph_nxt = PH_RX;
               tick_nxt = HALF_LAST;
               bit_nxt = 4'h0;
            end
         end
         PH_RX: begin
            if (tick_r != 4'h0) begin
               tick_nxt = tick_r - 4'h1;
            end else begin
               tick_nxt = BIT_LAST;
               bit_nxt = bit_r + 4'h1;
               if (bit_r == 4'h0 && lvl_r) begin
                  ph_nxt = PH_IDLE;
               end else if (bit_r == RX_STOP_BIT) begin
                  ph_nxt = PH_IDLE;
                  rx_stb = lvl_r;
               end else if (bit_r != 4'h0) begin
                  sh_nxt = {sh_r[10:8], lvl_r, sh_r[7:1]};
               end
            end
         end
         PH_TX: begin
            if (tick_r != 4'h0) begin
               tick_nxt = tick_r - 4'h1;
            end else begin
               tick_nxt = BIT_LAST;
               bit_nxt = bit_r + 4'h1;
               sh_nxt = {1'b1, sh_r[10:1]};
               if (bit_r == TX_LAST_BIT) begin
                  ph_nxt = PH_IDLE;
                  tx_done = 1'b1;
                  oen_nxt = 1'b1;
               end else begin
                  oen_nxt = sh_r[1];
               end
            end
         end
         default: begin
            ph_nxt = PH_IDLE;
            oen_nxt = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ph_r <= PH_IDLE;
         tick_r <= 4'h0;
         bit_r <= 4'h0;
         sh_r <= SH_RST;
         oen_r <= 1'b1;
      end else begin
         ph_r <= ph_nxt;
         tick_r <= tick_nxt;
         bit_r <= bit_nxt;
         sh_r <= sh_nxt;
         oen_r <= oen_nxt;
      end
   end

   // ==========================================
   // command sequencer
   host_state_e st_r, st_nxt;
   logic [7:0] op_r, op_nxt, hdr, rdd_r, rdd_nxt;
   logic [15:0] addr_r, addr_nxt, size_r, size_nxt;
   logic [16:0] cnt_r, cnt_nxt;
   logic [2:0] idx_r, idx_nxt, idx_last;
   logic rdv_r, rdv_nxt;

   assign idx_last = (op_r == OP_REG_RD) ? 3'h3 : 3'h4;
   assign cmd_ready = (st_r == H_IDLE);
   assign wr_ready = (st_r == H_WDATA) && (ph_r == PH_IDLE);
   assign tx_go = (st_r == H_HDR) || (wr_ready && wr_valid);
   assign tx_byte = (st_r == H_HDR) ? hdr : wr_data;
   assign rd_valid = rdv_r;
   assign rd_data = rdd_r;
   assign busy = (st_r != H_IDLE);

   always_comb begin
      case (idx_r)
         3'h0: hdr = op_r;
         3'h1: hdr = (op_r == OP_REG_RD) ? {4'h0, addr_r[11:8]} : addr_r[15:8];
         3'h2: hdr = addr_r[7:0];
         3'h3: hdr = (op_r == OP_REG_RD) ? size_r[7:0] : size_r[15:8];
         3'h4: hdr = size_r[7:0];
         default: hdr = BYTE_RST;
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      op_nxt = op_r;
      addr_nxt = addr_r;
      size_nxt = size_r;
      cnt_nxt = cnt_r;
      idx_nxt = idx_r;
      rdv_nxt = 1'b0;
      rdd_nxt = rdd_r;
      case (st_r)
         H_IDLE: begin
            if (cmd_valid) begin
               op_nxt = cmd_op;
               addr_nxt = cmd_addr;
               size_nxt = cmd_size;
               idx_nxt = IDX_RST;
               if (cmd_op == OP_REG_RD) begin
                  cnt_nxt = (cmd_size[7:0] == 8'h00) ? REG_MAX : {9'h000, cmd_size[7:0]};
               end else begin
                  cnt_nxt = (cmd_size == 16'h0000) ? MEM_MAX : {1'b0, cmd_size};
               end
               st_nxt = H_HDR;
            end
         end
         H_HDR: begin
            st_nxt = H_HWAIT;
         end
         H_HWAIT: begin
            if (tx_done) begin
               idx_nxt = idx_r + 3'h1;
               if (idx_r != idx_last) begin
                  st_nxt = H_HDR;
               end else if (op_r == OP_PM_WR || op_r == OP_DM_WR) begin
                  st_nxt = H_WDATA;
               end else if (op_r == OP_REG_RD || op_r == OP_PM_RD) begin
                  st_nxt = H_READ;
               end else begin
                  st_nxt = H_IDLE;
               end
            end
         end
         H_WDATA: begin
            if (wr_valid && wr_ready) begin
               st_nxt = H_WWAIT;
            end
         end
         H_WWAIT: begin
            if (tx_done) begin
               cnt_nxt = cnt_r - CNT_ONE;
               st_nxt = (cnt_r == CNT_ONE) ? H_IDLE : H_WDATA;
            end
         end
         H_READ: begin
            if (rx_stb) begin
               rdv_nxt = 1'b1;
               rdd_nxt = sh_r[7:0];
               cnt_nxt = cnt_r - CNT_ONE;
               if (cnt_r == CNT_ONE) begin
                  st_nxt = H_IDLE;
               end
            end
         end
         default: begin
            st_nxt = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         st_r <= H_IDLE;
         op_r <= BYTE_RST;
         addr_r <= ADDR_RST;
         size_r <= ADDR_RST;
         cnt_r <= CNT_RST;
         idx_r <= IDX_RST;
         rdv_r <= 1'b0;
         rdd_r <= BYTE_RST;
      end else begin
         st_r <= st_nxt;
         op_r <= op_nxt;
         addr_r <= addr_nxt;
         size_r <= size_nxt;
         cnt_r <= cnt_nxt;
         idx_r <= idx_nxt;
         rdv_r <= rdv_nxt;
         rdd_r <= rdd_nxt;
      end
   end

endmodule : debug_cmd_host

// *** verification/dbg_link_checker.sv ***
// assertions on the debug link and the device's memory side
`timescale 1ns/10ps
module dbg_link_checker (
   input wire logic clock,
   input wire logic nrst,
   input wire logic dev_o,
   input wire logic dev_oe_n,
   input wire logic host_o,
   input wire logic debug_mode,
   input wire logic read_protect,
   input wire logic flash_unlocked,
   input wire dbg_cmd_pkg::space_e mem_space,
   input wire logic [15:0] mem_addr,
   input wire logic mem_we,
   input wire logic mem_re,
   input wire logic busy
);
   import dbg_cmd_pkg::*;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   // ==========================================
   // address of the last write strobe
   logic [15:0] wa_r;
   logic [15:0] wa_nxt;
   always_comb begin
      wa_nxt = mem_we ? mem_addr : wa_r;
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wa_r <= ADDR_RST;
      end else begin
         wa_r <= wa_nxt;
      end
   end
   // ==========================================
   // properties
   chk_open_drain: assert property (dev_o == 1'b0 && host_o == 1'b0)
      else $error("link data driven high");
   chk_start_len: assert property ($fell(dev_oe_n) |-> (!dev_oe_n) [*8])
      else $error("short low bit on link");
   chk_idle_quiet: assert property (!busy |-> dev_oe_n)
      else $error("device drives link while idle");
   chk_we_gate: assert property (mem_we |-> debug_mode && !read_protect)
      else $error("write while locked or protected");
   chk_pm_unlock: assert property (mem_we && mem_space == SP_PROG |-> flash_unlocked)
      else $error("program write while flash locked");
   chk_we_pulse: assert property (mem_we |=> (!mem_we) [*8])
      else $error("write strobe too long");
   chk_re_pulse: assert property (mem_re |=> (!mem_re) [*8])
      else $error("read strobe too long");
   chk_re_space: assert property (mem_re |-> mem_space != SP_DATA)
      else $error("read from data space");
   chk_addr_step: assert property (mem_we |=> ##[0:1] mem_addr == wa_r + 16'h0001)
      else $error("address did not step after write");
endmodule : dbg_link_checker

// *** verification/tb.sv ***
// self-checking bench: host and device ends joined on one link
`timescale 1ns/10ps
module tb;
   import dbg_cmd_pkg::*;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic debug_mode = 1'b1;
   logic read_protect = 1'b0;
   logic flash_unlocked = 1'b1;
   logic cmd_valid = 1'b0;
   logic [7:0] cmd_op = 8'h00;
   logic [15:0] cmd_addr = 16'h0000;
   logic [15:0] cmd_size = 16'h0000;
   logic wr_valid = 1'b0;
   logic [7:0] wr_data = 8'h00;
   logic [7:0] mem_rdata = 8'h00;
   space_e mem_space;
   logic [15:0] mem_addr;
   logic [7:0] mem_wdata, rd_data;
   logic mem_we, mem_re, d_busy, h_busy, cmd_ready, wr_ready, rd_valid;
   logic re_d = 1'b0;
   logic [25:0] wq[$];
   int rd_cnt = 0;
   int fails = 0;
   int num_checks = 0;

   debug_link_if u_debug_link_if ();
   debug_cmd_device u_debug_cmd_device (.clock(clock), .nrst(nrst),
      .link(u_debug_link_if.device), .debug_mode(debug_mode), .read_protect(read_protect),
      .flash_unlocked(flash_unlocked), .mem_space(mem_space), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata),
      .busy(d_busy));
   debug_cmd_host u_debug_cmd_host (.clock(clock), .nrst(nrst),
      .link(u_debug_link_if.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_size(cmd_size), .wr_valid(wr_valid),
      .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data),
      .busy(h_busy));
   dbg_link_checker u_dbg_link_checker (.clock(clock), .nrst(nrst),
      .dev_o(u_debug_link_if.dev_o), .dev_oe_n(u_debug_link_if.dev_oe_n),
      .host_o(u_debug_link_if.host_o), .debug_mode(debug_mode),
      .read_protect(read_protect), .flash_unlocked(flash_unlocked),
      .mem_space(mem_space), .mem_addr(mem_addr), .mem_we(mem_we), .mem_re(mem_re),
      .busy(d_busy));

   initial begin
      forever #20 clock = ~clock;
   end

   // ==========================================
   // memory beside the device
   function automatic logic [7:0] mem_val(input logic [1:0] sp, input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ {6'h00, sp};
   endfunction : mem_val

   // data is inverted between reads so a stale value never matches
   always @(posedge clock) begin
      re_d <= mem_re;
      // held two cycles: the device loads its reply byte two cycles after the strobe
      mem_rdata <= mem_re ? mem_val(mem_space, mem_addr) : (re_d ? mem_rdata : ~mem_rdata);
      if (mem_we === 1'b1) wq.push_back({mem_space, mem_addr, mem_wdata});
      if (rd_valid === 1'b1) rd_cnt <= rd_cnt + 1;
   end

   // ==========================================
   // shared tasks
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic start_cmd(input logic [7:0] op, input logic [15:0] a, input logic [15:0] n);
      cmd_op = op;
      cmd_addr = a;
      cmd_size = n;
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1) @(posedge clock) #1;
      @(posedge clock);
      #1 cmd_valid = 1'b0;
   endtask : start_cmd

   task automatic wait_idle();
      for (int i = 0; i < 4000 && (h_busy !== 1'b0 || d_busy !== 1'b0); i++) @(negedge clock);
      check("busy", 2'h0, {h_busy, d_busy});
      @(posedge clock);
      #1;
   endtask : wait_idle

   task automatic do_read(input logic [7:0] op, input logic [15:0] a, input logic [15:0] n,
      input int cnt, input logic blk);
      logic [15:0] ma;
      logic [1:0] sp;
      sp = (op == OP_REG_RD) ? SP_REG : SP_PROG;
      ma = (op == OP_REG_RD) ? {4'h0, a[11:0]} : a;
      rd_cnt = 0;
      start_cmd(op, a, n);
      for (int i = 0; i < cnt; i++) begin
         do @(negedge clock); while (rd_valid !== 1'b1);
         check("rd_data", blk ? BLOCKED_BYTE : mem_val(sp, ma + 16'(i)), rd_data);
      end
      wait_idle();
      check("rd_count", cnt, rd_cnt);
   endtask : do_read

   // ==========================================
   // scenarios
   task automatic s_reg_rd();
      // upper nibble dropped, carry from 3ff into 400
      do_read(OP_REG_RD, 16'hf3fe, 16'h0003, 3, 1'b0);
   endtask : s_reg_rd

   task automatic s_reg_full();
      do_read(OP_REG_RD, 16'h0200, 16'h0000, 256, 1'b0);
   endtask : s_reg_full

   task automatic s_pm_rd();
      do_read(OP_PM_RD, 16'hfffe, 16'h0003, 3, 1'b0);
   endtask : s_pm_rd

   task automatic s_blocked();
      for (int k = 0; k < 4; k++) begin
         debug_mode = k[0];
         read_protect = k[0];
         do_read(k[1] ? OP_PM_RD : OP_REG_RD, 16'h0010, 16'h0002, 2, 1'b1);
      end
      debug_mode = 1'b1;
      read_protect = 1'b0;
   endtask : s_blocked

   task automatic s_writes();
      logic [7:0] ops[6] = '{OP_PM_WR, OP_PM_WR, OP_PM_WR, OP_PM_WR, OP_DM_WR, OP_DM_WR};
      logic [2:0] cfg[6] = '{3'b101, 3'b100, 3'b001, 3'b111, 3'b100, 3'b110};
      logic ok;
      logic [1:0] sp;
      for (int k = 0; k < 6; k++) begin
         {debug_mode, read_protect, flash_unlocked} = cfg[k];
         ok = cfg[k][2] && !cfg[k][1] && (ops[k] == OP_DM_WR || cfg[k][0]);
         sp = (ops[k] == OP_PM_WR) ? SP_PROG : SP_DATA;
         wq.delete();
         start_cmd(ops[k], 16'hffff, 16'h0002);
         for (int i = 0; i < 2; i++) begin
            wr_data = 8'h30 + 8'(k * 2 + i);
            wr_valid = 1'b1;
            while (wr_ready !== 1'b1) @(posedge clock) #1;
            @(posedge clock);
            #1;
         end
         wr_valid = 1'b0;
         wait_idle();
         check("writes", ok ? 2 : 0, wq.size());
         if (ok) begin
            check("wr0", {sp, 16'hffff, 8'h30 + 8'(k * 2)}, wq[0]);
            check("wr1", {sp, 16'h0000, 8'h31 + 8'(k * 2)}, wq[1]);
         end
      end
      {debug_mode, read_protect, flash_unlocked} = 3'b101;
   endtask : s_writes

   initial begin
      repeat (2) @(posedge clock);
      #1 nrst = 1'b1;
      s_reg_rd();
      s_pm_rd();
      s_blocked();
      s_writes();
      s_reg_full();
      end_sim();
   end

   initial begin
      #(40 * 80000);
      fails++;
      $display("Error watchdog expected idle seen hang");
      end_sim();
   end
endmodule : tb
